// *** rtl/fpkt_ctrl.sv ***
// Purpose: packet controller for the fast long-range modem: commands, timeouts,
//   interrupt flags, pin mapping, packet status and receive buffer status
// Assumes: host commands arrive as one-cycle strobes; modem events are pulses
// Notes: payload bytes leave through a two-entry buffer toward the modem
`timescale 1ns/1ns
// Summary of operation
// - buffer write starts at the given offset
// - transmit end sets flag, returns to standby
// - nonzero transmit count arms timeout to standby
// - third status bit 0 means sent
// - third status: packet id and no-ack
// - bit 4 flags repeated id and checksum
// - clear resets only flags selected in mask
// - receive flag on any packet; host checks
// - sync and check failure flags during receive
// - count zero: single receive, no timeout
// - count all ones: continuous receive
// - other count: timer, stopped on detection
// - strength captured at sync detection
// - second status bit 6: sync status
// - second status bit 5: oversize
// - second status bit 4: check failure, stored
// - bit 3 aborted, bit 0 busy
// - bit 2 header seen, bit 1 received
// - fourth status: correlator match code
// - pins are OR of mapped flags
// - buffer query returns length and offset
module fpkt_ctrl #(
  parameter int BUF_AW = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input wire logic [3:0] i_cmd,
  input wire logic [15:0] i_cmd_arg,
  input wire logic [7:0] i_cmd_arg2,
  input wire logic [fpkt_pkg::IRQ_W-1:0] i_map1,
  input wire logic [fpkt_pkg::IRQ_W-1:0] i_map2,
  input wire logic [fpkt_pkg::IRQ_W-1:0] i_map3,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_data,
  output logic o_busy,
  output logic [7:0] o_rsp0,
  output logic [7:0] o_rsp1,
  output logic [7:0] o_rsp2,
  output logic [7:0] o_rsp3,
  output logic o_rsp_valid,
  output logic [fpkt_pkg::IRQ_W-1:0] o_irq_flags,
  output logic o_digital_out_pin_one,
  output logic o_digital_out_pin_two,
  output logic o_digital_out_pin_three,
  // modem side
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  input wire logic i_tx_end,
  input wire logic i_rx_sync,
  input wire logic [7:0] i_rx_strength,
  input wire logic [2:0] i_rx_corr,
  input wire logic i_rx_header,
  input wire logic i_rx_end,
  input wire logic i_rx_crc_bad,
  input wire logic i_rx_crc_en,
  input wire logic i_rx_dyn,
  input wire logic i_rx_sync_en,
  input wire logic [1:0] i_rx_pid,
  input wire logic i_rx_noack,
  input wire logic [15:0] i_rx_crc,
  input wire logic i_pid_filter_en,
  input wire logic [7:0] i_rx_len,
  input wire logic [7:0] i_max_len,
  input wire logic [7:0] i_rx_base,
  input wire logic i_abort
);
  localparam int IRQ_W_C = fpkt_pkg::IRQ_W;
  localparam int DEPTH = 1 << BUF_AW;

  typedef enum logic [2:0] {
    ST_STBY = 3'b001,
    ST_TX = 3'b010,
    ST_RX = 3'b100
  } state_t;

  function automatic logic [15:0] steps_to_cyc(input logic [7:0] step);
    steps_to_cyc = {8'h00, step};
  endfunction

  state_t state_ff;
  state_t nxt_state;
  logic [7:0] mem [DEPTH];
  logic [BUF_AW-1:0] wptr_ff;
  logic [BUF_AW-1:0] rptr_ff;
  logic [8:0] tx_left_ff;
  logic [IRQ_W_C-1:0] flags_ff;
  logic [IRQ_W_C-1:0] map1_ff;
  logic [IRQ_W_C-1:0] map2_ff;
  logic [IRQ_W_C-1:0] map3_ff;
  logic pin1_ff;
  logic pin2_ff;
  logic pin3_ff;
  logic [15:0] periods_ff;
  logic [15:0] step_cyc_ff;
  logic [15:0] sub_ff;
  logic timer_on_ff;
  logic cont_ff;
  logic [7:0] st2_ff;
  logic [7:0] st3_ff;
  logic [7:0] st4_ff;
  logic [7:0] rssi_ff;
  logic [7:0] rx_len_ff;
  logic [7:0] rx_off_ff;
  logic [1:0] prev_pid_ff;
  logic [15:0] prev_crc_ff;
  logic prev_ok_ff;
  logic [7:0] rsp0_ff;
  logic [7:0] rsp1_ff;
  logic [7:0] rsp2_ff;
  logic [7:0] rsp3_ff;
  logic rsp_valid_ff;
  logic buf_ready;
  logic buf_valid;
  logic [7:0] buf_data;

  wire cmd_tx = i_cmd_valid && (i_cmd == fpkt_pkg::CMD_START_TX);
  wire cmd_rx = i_cmd_valid && (i_cmd == fpkt_pkg::CMD_START_RX);
  wire cmd_wr = i_cmd_valid && (i_cmd == fpkt_pkg::CMD_BUF_WRITE);
  wire cmd_map = i_cmd_valid && (i_cmd == fpkt_pkg::CMD_PIN_MAP);
  wire cmd_clr = i_cmd_valid && (i_cmd == fpkt_pkg::CMD_IRQ_CLEAR);
  wire cmd_pst = i_cmd_valid && (i_cmd == fpkt_pkg::CMD_PKT_STATUS);
  wire cmd_bst = i_cmd_valid && (i_cmd == fpkt_pkg::CMD_RXBUF_STATUS);
  wire cmd_rd = i_cmd_valid && (i_cmd == fpkt_pkg::CMD_BUF_READ);
  wire cmd_sby = i_cmd_valid && (i_cmd == fpkt_pkg::CMD_STANDBY);
  wire in_tx = (state_ff == ST_TX);
  wire in_rx = (state_ff == ST_RX);
  wire tx_load = in_tx && (tx_left_ff != 9'd0) && buf_ready;
  wire sub_end = (sub_ff == 16'd1);
  wire timer_exp = timer_on_ff && sub_end && (periods_ff == 16'd1);
  wire tx_done = in_tx && i_tx_end;
  wire rx_done = in_rx && i_rx_end;
  wire pid_rep = i_rx_dyn && i_pid_filter_en && prev_ok_ff &&
                 (i_rx_pid == prev_pid_ff) && (i_rx_crc == prev_crc_ff);

  wire [IRQ_W_C-1:0] ev_set = {timer_exp, rx_done && i_rx_crc_en && i_rx_crc_bad,
                               in_rx && i_rx_sync, rx_done, tx_done};
  wire [IRQ_W_C-1:0] nxt_flags = (flags_ff & ~(cmd_clr ? i_cmd_arg[IRQ_W_C-1:0] : '0)) | ev_set;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_STBY: begin
        if (cmd_tx) begin
          nxt_state = ST_TX;
        end else if (cmd_rx) begin
          nxt_state = ST_RX;
        end
      end
      ST_TX: begin
        if (tx_done || timer_exp || cmd_sby || i_abort) begin
          nxt_state = ST_STBY;
        end
      end
      ST_RX: begin
        if ((rx_done && !cont_ff) || timer_exp || cmd_sby || i_abort) begin
          nxt_state = ST_STBY;
        end
      end
      default: nxt_state = ST_STBY;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state_ff <= ST_STBY;
      flags_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (cmd_wr) begin
      wptr_ff <= i_cmd_arg[BUF_AW-1:0];
    end else if (i_wr_valid) begin
      mem[wptr_ff] <= i_wr_data;
      wptr_ff <= wptr_ff + 1'b1;
    end
  end

  // transmit read pointer and byte count; start at i_rx_base, length from i_max_len
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      rptr_ff <= '0;
      tx_left_ff <= 9'd0;
    end else if (cmd_tx && !in_tx && !in_rx) begin
      rptr_ff <= i_rx_base[BUF_AW-1:0];
      tx_left_ff <= {1'b0, i_max_len};
    end else if (tx_load) begin
      rptr_ff <= rptr_ff + 1'b1;
      tx_left_ff <= tx_left_ff - 9'd1;
    end else if (!in_tx) begin
      tx_left_ff <= 9'd0;
    end
  end

  // stall by the modem holds the read pointer, so no byte is skipped
  fpkt_skid #(.W(8)) fpkt_skid_i (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_valid(tx_load),
    .o_ready(buf_ready),
    .i_data(mem[rptr_ff]),
    .o_valid(buf_valid),
    .i_ready(i_tx_ready),
    .o_data(buf_data)
  );

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      timer_on_ff <= 1'b0;
      cont_ff <= 1'b0;
      periods_ff <= 16'd0;
      sub_ff <= 16'd0;
      step_cyc_ff <= 16'd1;
    end else if ((cmd_tx || cmd_rx) && state_ff == ST_STBY) begin
      cont_ff <= cmd_rx && (i_cmd_arg == fpkt_pkg::RX_CONT);
      timer_on_ff <= (i_cmd_arg != fpkt_pkg::RX_SINGLE) &&
                     !(cmd_rx && i_cmd_arg == fpkt_pkg::RX_CONT);
      periods_ff <= i_cmd_arg;
      step_cyc_ff <= steps_to_cyc(i_cmd_arg2) * 16'(fpkt_pkg::STEP_CYC);
      sub_ff <= steps_to_cyc(i_cmd_arg2) * 16'(fpkt_pkg::STEP_CYC);
    end else if (nxt_state == ST_STBY || (in_rx && i_rx_sync)) begin
      timer_on_ff <= 1'b0;
    end else if (timer_on_ff) begin
      if (sub_end) begin
        sub_ff <= step_cyc_ff;
        periods_ff <= periods_ff - 16'd1;
      end else begin
        sub_ff <= sub_ff - 16'd1;
      end
    end
  end

  // packet status capture
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      st2_ff <= fpkt_pkg::STATUS_RST;
      st3_ff <= fpkt_pkg::STATUS_RST;
      st4_ff <= fpkt_pkg::STATUS_RST;
      rssi_ff <= 8'h00;
      rx_len_ff <= 8'h00;
      rx_off_ff <= 8'h00;
      prev_pid_ff <= 2'b00;
      prev_crc_ff <= 16'h0000;
      prev_ok_ff <= 1'b0;
    end else begin
      // busy while in transmit or receive
      st2_ff[fpkt_pkg::S2_BUSY] <= (nxt_state != ST_STBY);
      if ((cmd_tx || cmd_rx) && state_ff == ST_STBY) begin
        st2_ff[7:1] <= 7'h00;
        st3_ff <= fpkt_pkg::STATUS_RST;
      end
      if ((in_tx || in_rx) && i_abort) begin
        st2_ff[fpkt_pkg::S2_ABORT] <= 1'b1;
      end
      if (tx_done) begin
        st3_ff[fpkt_pkg::S3_SENT] <= 1'b1;
      end
      if (in_rx && i_rx_sync) begin
        rssi_ff <= i_rx_strength;
        st4_ff <= {5'b00000, i_rx_corr};
        st2_ff[fpkt_pkg::S2_SYNC] <= i_rx_sync_en && (i_rx_corr == 3'b000);
      end
      if (in_rx && i_rx_header && i_rx_dyn) begin
        st2_ff[fpkt_pkg::S2_HDR] <= 1'b1;
      end
      if (rx_done) begin
        st2_ff[fpkt_pkg::S2_RXFIN] <= 1'b1;
        st2_ff[fpkt_pkg::S2_LEN] <= i_rx_dyn && (i_rx_len > i_max_len);
        st2_ff[fpkt_pkg::S2_CRC] <= i_rx_crc_en && i_rx_crc_bad;
        st3_ff <= i_rx_dyn ? {i_rx_pid, i_rx_noack, pid_rep, 4'b0000} : 8'h00;
        prev_pid_ff <= i_rx_pid;
        prev_crc_ff <= i_rx_crc;
        prev_ok_ff <= 1'b1;
        rx_len_ff <= i_rx_len;
        rx_off_ff <= i_rx_base;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      map1_ff <= '0;
      map2_ff <= '0;
      map3_ff <= '0;
      pin1_ff <= 1'b0;
      pin2_ff <= 1'b0;
      pin3_ff <= 1'b0;
    end else begin
      if (cmd_map) begin
        map1_ff <= i_map1;
        map2_ff <= i_map2;
        map3_ff <= i_map3;
      end
      pin1_ff <= |(nxt_flags & map1_ff);
      pin2_ff <= |(nxt_flags & map2_ff);
      pin3_ff <= |(nxt_flags & map3_ff);
    end
  end

  // command responses; buffer read returns one byte at the given offset
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      rsp0_ff <= 8'h00;
      rsp1_ff <= 8'h00;
      rsp2_ff <= 8'h00;
      rsp3_ff <= 8'h00;
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= cmd_pst || cmd_bst || cmd_rd;
      if (cmd_pst) begin
        rsp0_ff <= rssi_ff;
        rsp1_ff <= {1'b0, st2_ff[6:0]};
        rsp2_ff <= {st3_ff[7:4], 3'b000, st3_ff[0]};
        rsp3_ff <= {5'b00000, st4_ff[2:0]};
      end else if (cmd_bst) begin
        rsp0_ff <= rx_len_ff;
        rsp1_ff <= rx_off_ff;
        rsp2_ff <= 8'h00;
        rsp3_ff <= 8'h00;
      end else if (cmd_rd) begin
        rsp0_ff <= mem[i_cmd_arg[BUF_AW-1:0]];
        rsp1_ff <= 8'h00;
        rsp2_ff <= 8'h00;
        rsp3_ff <= 8'h00;
      end
    end
  end

  assign o_busy = st2_ff[fpkt_pkg::S2_BUSY];
  assign o_rsp0 = rsp0_ff;
  assign o_rsp1 = rsp1_ff;
  assign o_rsp2 = rsp2_ff;
  assign o_rsp3 = rsp3_ff;
  assign o_rsp_valid = rsp_valid_ff;
  assign o_irq_flags = flags_ff;
  assign o_digital_out_pin_one = pin1_ff;
  assign o_digital_out_pin_two = pin2_ff;
  assign o_digital_out_pin_three = pin3_ff;
  assign o_tx_valid = buf_valid;
  assign o_tx_data = buf_data;

  a_tx_flag: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    tx_done |=> state_ff == ST_STBY && flags_ff[fpkt_pkg::IRQ_TX_DONE])
    else $error("transmit end did not reach standby");
  a_tx_stby: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    tx_done |=> state_ff == ST_STBY)
    else $error("transmit end state wrong");
  a_timeout: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    timer_exp |=> flags_ff[fpkt_pkg::IRQ_TIMEOUT] && state_ff == ST_STBY)
    else $error("timeout not handled");
  a_clear: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    cmd_clr && ev_set == '0 |=> flags_ff == ($past(flags_ff) & ~$past(i_cmd_arg[IRQ_W_C-1:0])))
    else $error("clear mask wrong");
  a_cont: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    rx_done && cont_ff && !timer_exp && !cmd_sby && !i_abort |=> state_ff == ST_RX)
    else $error("continuous receive left");
  a_single: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    rx_done && !cont_ff |=> state_ff == ST_STBY ##0 flags_ff[fpkt_pkg::IRQ_RX_DONE])
    else $error("single receive stayed");
  a_timer_off: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    in_rx && i_rx_sync |=> !timer_on_ff)
    else $error("timer kept running after detection");
  a_pin1: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    ##1 pin1_ff == |($past(nxt_flags) & $past(map1_ff)))
    else $error("pin one mismatch");
  a_busy: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_busy == (state_ff != ST_STBY))
    else $error("busy bit wrong");
  a_resv: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    rsp_valid_ff && $past(cmd_pst) |-> rsp1_ff[7] == 1'b0 && rsp2_ff[3:1] == 3'b000)
    else $error("reserved bits set");
endmodule

// *** rtl/fpkt_pkg.sv ***
// Purpose: shared constants for the fast packet transmit/receive controller
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: command codes and flag positions are local to this block
package fpkt_pkg;
  localparam int CLK_MHZ = 100;
  // timeout step of 1 us per count unit, expressed in cycles
  localparam int STEP_NS = 1000;
  localparam int STEP_CYC = (STEP_NS * CLK_MHZ) / 1000;
  // command codes on the host command port
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_START_TX = 4'h1;
  localparam logic [3:0] CMD_START_RX = 4'h2;
  localparam logic [3:0] CMD_BUF_WRITE = 4'h3;
  localparam logic [3:0] CMD_BUF_READ = 4'h4;
  localparam logic [3:0] CMD_PIN_MAP = 4'h5;
  localparam logic [3:0] CMD_IRQ_CLEAR = 4'h6;
  localparam logic [3:0] CMD_PKT_STATUS = 4'h7;
  localparam logic [3:0] CMD_RXBUF_STATUS = 4'h8;
  localparam logic [3:0] CMD_STANDBY = 4'h9;
  // interrupt flag positions
  localparam int IRQ_W = 5;
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_RX_DONE = 1;
  localparam int IRQ_SYNC = 2;
  localparam int IRQ_CRC = 3;
  localparam int IRQ_TIMEOUT = 4;
  // receive period count meanings
  localparam logic [15:0] RX_SINGLE = 16'h0000;
  localparam logic [15:0] RX_CONT = 16'hFFFF;
  // status byte bit positions
  localparam int S2_SYNC = 6;
  localparam int S2_LEN = 5;
  localparam int S2_CRC = 4;
  localparam int S2_ABORT = 3;
  localparam int S2_HDR = 2;
  localparam int S2_RXFIN = 1;
  localparam int S2_BUSY = 0;
  localparam int S3_PID = 6;
  localparam int S3_NOACK = 5;
  localparam int S3_PIDERR = 4;
  localparam int S3_SENT = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;
endpackage

// *** rtl/fpkt_skid.sv ***
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes: full registered ready, no word lost on a stall
`timescale 1ns/1ns
module fpkt_skid #(
  parameter int W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  logic [W-1:0] mem_ff [2];
  logic wr_ff;
  logic rd_ff;
  logic [1:0] cnt_ff;
  wire push = i_valid && (cnt_ff != 2'd2);
  wire pop = (cnt_ff != 2'd0) && i_ready;
  assign o_ready = (cnt_ff != 2'd2);
  assign o_valid = (cnt_ff != 2'd0);
  assign o_data = mem_ff[rd_ff];
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      cnt_ff <= 2'd0;
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else begin
      if (push) begin
        mem_ff[wr_ff] <= i_data;
        wr_ff <= ~wr_ff;
      end
      if (pop) begin
        rd_ff <= ~rd_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// *** testbench/fpkt_modem_model.sv ***
// Purpose: modem-side partner: takes payload bytes, raises packet events
// Assumes: one clock, everything driven just after the rising edge
// Notes: i_hang withholds the end-of-transmit pulse so a timeout can run out
`timescale 1ns/1ns
module fpkt_modem_model (
  input wire logic i_clk_sys,
  input wire logic i_hang,
  input wire logic [7:0] i_max_len,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic o_tx_end,
  output logic o_rx_sync,
  output logic [7:0] o_rx_strength,
  output logic [2:0] o_rx_corr,
  output logic o_rx_header,
  output logic o_rx_end,
  output logic o_rx_crc_bad,
  output logic [1:0] o_rx_pid,
  output logic o_rx_noack,
  output logic [15:0] o_rx_crc,
  output logic [7:0] o_rx_len,
  output logic o_abort
);
  int n_taken = 0;
  logic in_pkt = 1'b0;

  initial begin
    {o_tx_ready, o_tx_end, o_rx_sync, o_rx_header, o_rx_end, o_rx_crc_bad, o_abort} = 7'h00;
    {o_rx_strength, o_rx_corr, o_rx_pid, o_rx_noack, o_rx_crc} = 30'h0000_0000;
    o_rx_len = 8'h00;
  end

  // end pulse once the whole payload is out
  always @(posedge i_clk_sys) begin
    o_tx_ready <= ($urandom_range(3) != 0);
    o_tx_end <= 1'b0;
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) n_taken++;
    if (n_taken == int'(i_max_len)) begin
      n_taken = 0;
      o_tx_end <= !i_hang;
    end
    // strength, correlator, id, no-ack and checksum levels carry noise outside a packet; length and check failure keep the last packet's value
    if (!in_pkt) {o_rx_strength, o_rx_corr, o_rx_pid, o_rx_noack, o_rx_crc} <= 30'($urandom);
  end

  // sync, header and end events of one packet
  task automatic rx_packet(input logic [2:0] corr, input logic [1:0] pid, input logic [15:0] crc,
                           input logic bad, input logic [7:0] len, input int gap);
    in_pkt = 1'b1;
    {o_rx_strength, o_rx_corr, o_rx_pid, o_rx_noack, o_rx_crc} <= {8'h5c, corr, pid, pid[0], crc};
    o_rx_crc_bad <= bad;
    o_rx_len <= len;
    o_rx_sync <= 1'b1;
    @(posedge i_clk_sys);
    o_rx_sync <= 1'b0;
    o_rx_header <= 1'b1;
    @(posedge i_clk_sys);
    o_rx_header <= 1'b0;
    repeat (gap) @(posedge i_clk_sys);
    o_rx_end <= 1'b1;
    @(posedge i_clk_sys);
    o_rx_end <= 1'b0;
    in_pkt = 1'b0;
  endtask

  // one-cycle abort request from the modem
  task automatic abort_pulse();
    o_abort <= 1'b1;
    @(posedge i_clk_sys);
    o_abort <= 1'b0;
  endtask
endmodule

// *** testbench/fpkt_ctrl_bench.sv ***
// Purpose: self-checking bench for the packet controller
// Assumes: 100 MHz clock, synchronous active-low reset held 8 cycles
// Notes: responses and payload bytes are checked from queues by monitors
`timescale 1ns/1ns
module fpkt_ctrl_bench;
  typedef struct {logic [31:0] exp; logic [31:0] mask;} rsp_note_t;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_cmd_valid = 1'b0, i_wr_valid = 1'b0, hang = 1'b0;
  logic [3:0] i_cmd = 4'h0;
  logic [15:0] i_cmd_arg = 16'h0000;
  logic [7:0] i_cmd_arg2 = 8'h00, i_wr_data = 8'h00, base = 8'h20, max_len = 8'h06;
  logic [fpkt_pkg::IRQ_W-1:0] map1 = 5'h11, map2 = 5'h0a, map3 = 5'h04;
  logic dyn = 1'b1, crc_en = 1'b1, sync_en = 1'b1, pfe = 1'b1;
  logic o_busy, o_rsp_valid, o_tx_valid, tx_ready, tx_end, rx_sync, rx_header, rx_end, crc_bad, noack, abort;
  logic p1, p2, p3;
  logic [7:0] o_rsp0, o_rsp1, o_rsp2, o_rsp3, o_tx_data, strength, rx_len;
  logic [fpkt_pkg::IRQ_W-1:0] o_irq_flags;
  logic [2:0] corr, c;
  logic [1:0] pid;
  logic [15:0] rx_crc;
  logic [7:0] mem [0:5];
  logic [7:0] q_tx[$];
  rsp_note_t q_rsp[$];
  rsp_note_t note;
  int n_errors = 0, checks = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  fpkt_ctrl fpkt_ctrl_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_cmd_arg(i_cmd_arg), .i_cmd_arg2(i_cmd_arg2), .i_map1(map1), .i_map2(map2), .i_map3(map3),
    .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data), .o_busy(o_busy), .o_rsp0(o_rsp0), .o_rsp1(o_rsp1),
    .o_rsp2(o_rsp2), .o_rsp3(o_rsp3), .o_rsp_valid(o_rsp_valid), .o_irq_flags(o_irq_flags),
    .o_digital_out_pin_one(p1), .o_digital_out_pin_two(p2), .o_digital_out_pin_three(p3),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(tx_ready), .i_tx_end(tx_end),
    .i_rx_sync(rx_sync), .i_rx_strength(strength), .i_rx_corr(corr), .i_rx_header(rx_header),
    .i_rx_end(rx_end), .i_rx_crc_bad(crc_bad), .i_rx_crc_en(crc_en), .i_rx_dyn(dyn), .i_rx_sync_en(sync_en),
    .i_rx_pid(pid), .i_rx_noack(noack), .i_rx_crc(rx_crc), .i_pid_filter_en(pfe), .i_rx_len(rx_len),
    .i_max_len(max_len), .i_rx_base(base), .i_abort(abort));

  fpkt_modem_model fpkt_modem_model_i (.i_clk_sys(i_clk_sys), .i_hang(hang), .i_max_len(max_len),
    .i_tx_valid(o_tx_valid), .o_tx_ready(tx_ready), .o_tx_end(tx_end), .o_rx_sync(rx_sync),
    .o_rx_strength(strength), .o_rx_corr(corr), .o_rx_header(rx_header), .o_rx_end(rx_end),
    .o_rx_crc_bad(crc_bad), .o_rx_pid(pid), .o_rx_noack(noack), .o_rx_crc(rx_crc), .o_rx_len(rx_len),
    .o_abort(abort));

  task automatic cmp(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  always @(posedge i_clk_sys) begin
    if (o_rsp_valid === 1'b1) begin
      if (q_rsp.size() > 0) note = q_rsp.pop_front();
      else note = '{32'hffff_ffff, 32'hffff_ffff};
      cmp("response", {o_rsp3, o_rsp2, o_rsp1, o_rsp0} & note.mask, note.exp & note.mask);
    end
    if (o_tx_valid === 1'b1 && tx_ready === 1'b1) begin
      cmp("tx byte", {24'h0, o_tx_data}, (q_tx.size() > 0) ? {24'h0, q_tx.pop_front()} : 32'h100);
    end
  end

  task automatic cmd(input logic [3:0] code, input logic [15:0] a, input logic [7:0] a2);
    i_cmd <= code;
    i_cmd_arg <= a;
    i_cmd_arg2 <= a2;
    i_cmd_valid <= 1'b1;
    @(posedge i_clk_sys);
    i_cmd_valid <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic query(input logic [3:0] code, input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
    q_rsp.push_back('{e, m});
    cmd(code, a, 8'h00);
  endtask

  task automatic chk_state(input logic [4:0] f, input logic b);
    @(posedge i_clk_sys);
    cmp("flags", 32'(o_irq_flags), 32'(f));
    cmp("pins", {29'h0, p3, p2, p1}, {29'h0, |(f & map3), |(f & map2), |(f & map1)});
    cmp("busy", {31'h0, o_busy}, {31'h0, b});
  endtask

  task automatic wait_flag(input int b, input int lim);
    for (int k = 0; k < lim && o_irq_flags[b] !== 1'b1; k++) @(posedge i_clk_sys);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    void'($urandom(32'hc73a_911a));
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    chk_state(5'h00, 1'b0);
    cmd(fpkt_pkg::CMD_BUF_WRITE, {8'h00, base}, 8'h00);
    for (int k = 0; k < 6; k++) begin
      mem[k] = 8'($urandom);
      i_wr_data <= mem[k];
      i_wr_valid <= 1'b1;
      @(posedge i_clk_sys);
    end
    i_wr_valid <= 1'b0;
    cmd(fpkt_pkg::CMD_PIN_MAP, 16'h0000, 8'h00);
    for (int r = 0; r < 2; r++) foreach (mem[k]) q_tx.push_back(mem[k]);
    cmd(fpkt_pkg::CMD_START_TX, 16'h0000, 8'h01);
    wait_flag(fpkt_pkg::IRQ_TX_DONE, 200);
    chk_state(5'h01, 1'b0);
    query(fpkt_pkg::CMD_PKT_STATUS, 16'h0000, 32'h0001_0000, 32'hffff_ffff);
    query(fpkt_pkg::CMD_BUF_READ, {8'h00, base + 8'h03}, {24'h0, mem[3]}, 32'h0000_00ff);
    $display("test transmit done");
    hang <= 1'b1;
    cmd(fpkt_pkg::CMD_START_TX, 16'h0002, 8'h01);
    repeat (150) @(posedge i_clk_sys);
    chk_state(5'h01, 1'b1);
    wait_flag(fpkt_pkg::IRQ_TIMEOUT, 100);
    chk_state(5'h11, 1'b0);
    hang <= 1'b0;
    cmd(fpkt_pkg::CMD_IRQ_CLEAR, 16'h0001, 8'h00);
    chk_state(5'h10, 1'b0);
    cmd(fpkt_pkg::CMD_IRQ_CLEAR, 16'h0010, 8'h00);
    chk_state(5'h00, 1'b0);
    $display("test timeout and clear done");
    cmd(fpkt_pkg::CMD_START_RX, 16'h0000, 8'h01);
    repeat (300) @(posedge i_clk_sys);
    chk_state(5'h00, 1'b1);
    fpkt_modem_model_i.rx_packet(3'b001, 2'b01, 16'h1234, 1'b1, 8'h09, 20);
    chk_state(5'h0e, 1'b0);
    query(fpkt_pkg::CMD_PKT_STATUS, 16'h0000, 32'h0160_365c, 32'hffff_ffff);
    query(fpkt_pkg::CMD_RXBUF_STATUS, 16'h0000, {16'h0, base, 8'h09}, 32'h0000_ffff);
    cmd(fpkt_pkg::CMD_IRQ_CLEAR, 16'h001f, 8'h00);
    $display("test single receive done");
    cmd(fpkt_pkg::CMD_START_RX, 16'hffff, 8'h01);
    for (int k = 0; k < 4; k++) begin
      c = (k == 0) ? 3'b000 : 3'(1 << (k - 1));
      fpkt_modem_model_i.rx_packet(c, 2'b10, (k < 2) ? 16'h5a5a : 16'ha5a5, 1'b0, 8'h06, 5);
      chk_state(5'h06, 1'b1);
      query(fpkt_pkg::CMD_PKT_STATUS, 16'h0000, {5'h00, c, 2'b10, 1'b0, 1'(k), 4'h0,
        (c == 3'b000) ? 8'h47 : 8'h07, 8'h5c}, 32'hffff_ffff);
      cmd(fpkt_pkg::CMD_IRQ_CLEAR, 16'h001f, 8'h00);
    end
    cmd(fpkt_pkg::CMD_STANDBY, 16'h0000, 8'h00);
    chk_state(5'h00, 1'b0);
    $display("test continuous receive done");
    cmd(fpkt_pkg::CMD_START_RX, 16'h0003, 8'h01);
    wait_flag(fpkt_pkg::IRQ_TIMEOUT, 400);
    chk_state(5'h10, 1'b0);
    cmd(fpkt_pkg::CMD_IRQ_CLEAR, 16'h001f, 8'h00);
    cmd(fpkt_pkg::CMD_START_RX, 16'h0003, 8'h01);
    repeat (200) @(posedge i_clk_sys);
    pfe <= 1'b0;
    // same id and checksum as the last packet, but filtering off: no repeat flag
    fpkt_modem_model_i.rx_packet(3'b010, 2'b10, 16'ha5a5, 1'b0, 8'h06, 300);
    chk_state(5'h06, 1'b0);
    query(fpkt_pkg::CMD_PKT_STATUS, 16'h0000, 32'h0280_065c, 32'hffff_ffff);
    $display("test timed receive done");
    cmd(fpkt_pkg::CMD_IRQ_CLEAR, 16'h001f, 8'h00);
    dyn <= 1'b0;
    crc_en <= 1'b0;
    sync_en <= 1'b0;
    cmd(fpkt_pkg::CMD_START_RX, 16'h0000, 8'h01);
    fpkt_modem_model_i.rx_packet(3'b000, 2'b11, 16'h0f0f, 1'b1, 8'h09, 2);
    chk_state(5'h06, 1'b0);
    query(fpkt_pkg::CMD_PKT_STATUS, 16'h0000, 32'h0000_025c, 32'hffff_ffff);
    cmd(fpkt_pkg::CMD_IRQ_CLEAR, 16'h001f, 8'h00);
    cmd(fpkt_pkg::CMD_START_RX, 16'h0000, 8'h01);
    fpkt_modem_model_i.abort_pulse();
    chk_state(5'h00, 1'b0);
    query(fpkt_pkg::CMD_PKT_STATUS, 16'h0000, 32'h0000_085c, 32'hffff_ffff);
    $display("test enables off and abort done");
    repeat (5) @(posedge i_clk_sys);
    cmp("queues left", q_rsp.size() + q_tx.size(), 32'h0);
    summarize();
  end
endmodule
